// >>> bench/bbf_flash_model.sv
// behavioural boot-block flash on the far side of the host pins
`timescale 1ns/1ps
`default_nettype none
module bbf_flash_model
	import bbf_pkg::*;
#(
	parameter int	PROG_CYC = 1500,
	parameter int	ERASE_CYC = 300,
	// identity values are arbitrary
	parameter logic [7:0]	MFG_ID = 8'hA5,
	parameter logic [7:0]	DEV_ID = 8'h5A
) (
	input wire logic	i_clk,
	input wire bbf_pins_t	i_pins,
	input wire logic	i_powerdown_reset_n,
	input wire logic [7:0]	i_dq,
	output logic [7:0]	o_dq
);
	logic [7:0]	mem [2**ADDR_W];
	logic [7:0]	sr = 8'h80, flt = 8'h55, pv;
	logic [1:0]	mode = 0, pend = 0;
	logic [ADDR_W-1:0]	pa;
	logic	we_q = 1, hold = 0, prog = 0;
	int	busy = 0;
	// blank array reads as erased
	initial begin
		foreach (mem[i]) mem[i] = 8'hFF;
	end
	function automatic logic [7:0] rd(input logic [ADDR_W-1:0] ad);
		return mem[ad];
	endfunction
	// drive only in a read cycle, else a changing pattern
	// lowest address bit picks the signature code
	assign o_dq = (i_powerdown_reset_n && !i_pins.ce_n && !i_pins.oe_n && i_pins.we_n) ?
		(mode == 1 ? sr : mode == 2 ? (i_pins.addr[0] ? DEV_ID : MFG_ID) : rd(i_pins.addr)) : flt;
	always @(posedge i_clk) begin
		flt <= ~flt;
		we_q <= i_pins.we_n;
		if (!i_powerdown_reset_n) begin
			// power-down aborts and returns to array reads
			mode <= 0;
			pend <= 0;
			busy <= 0;
			hold <= 0;
		end else begin
			// ready only after the full duration
			if (busy > 0 && !hold) busy <= busy - 1;
			if (busy == 1 && !hold) begin
				sr[7] <= 1;
				if (prog) mem[pa] = rd(pa) & pv;
				else foreach (mem[i]) mem[i] = 8'hFF;
			end
			// decode the byte and latch address on the strobe rise
			if (!we_q && i_pins.we_n && !i_pins.ce_n) begin
				mode <= 1;
				pend <= 0;
				// program clears bits only, a failed bit latches the flag
				if (pend == 1) begin
					pa <= i_pins.addr;
					pv <= i_dq;
					prog <= 1;
					busy <= PROG_CYC;
					sr[7] <= 0;
					sr[4] <= sr[4] | ((rd(i_pins.addr) & i_dq) != i_dq);
				end else if (pend == 2) begin
					if (i_dq == CMD_CONFIRM) busy <= ERASE_CYC;
					prog <= 0;
					sr[7] <= i_dq != CMD_CONFIRM;
				end else if (busy > 0 && prog) begin
					mode <= 1;
				end else case (i_dq)
					CMD_READ_ARRAY: mode <= 0;
					CMD_SIGNATURE: mode <= 2;
					CMD_CLEAR_STATUS: sr[5:4] <= 0;
					CMD_PROG_SETUP, CMD_PROG_ALT: pend <= 1;
					CMD_ERASE_SETUP: pend <= 2;
					// suspend freezes a running erase, confirm resumes it
					CMD_SUSPEND: hold <= busy > 0;
					CMD_CONFIRM: hold <= 0;
					CMD_READ_STATUS: mode <= 1;
					default: mode <= mode;
				endcase
			end
		end
	end
endmodule // bbf_flash_model
`default_nettype wire

// >>> bench/bbf_host_monitor.sv
// checker for the flash host pin sequencing
`timescale 1ns/1ps
`default_nettype none
module bbf_host_monitor
	import bbf_pkg::*;
(
	// clock and reset
	input wire logic	i_sys_clk,
	input wire logic	i_rst_b,
	// watched outputs
	input wire logic	o_req_ready,
	input wire logic	o_done,
	input wire bbf_pins_t	o_pins,
	input wire logic	o_powerdown_reset_n,
	input wire logic [DATA_W-1:0]	o_dq_out,
	input wire logic	o_dq_oe
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);
	wr_cycle_a: assert property (
		!o_pins.we_n |-> !o_pins.ce_n && o_pins.oe_n && o_dq_oe) else $error("bad write");
	wr_width_a: assert property (
		$fell(o_pins.we_n) |-> !o_pins.we_n [*4] ##1 o_pins.we_n) else $error("strobe width");
	wr_hold_a: assert property (
		!o_pins.we_n |=> $stable(o_dq_out) && $stable(o_pins.addr)) else $error("write hold");
	rd_bus_a: assert property (
		!o_pins.oe_n |-> !o_pins.ce_n && o_pins.we_n && !o_dq_oe) else $error("bad read");
	rd_width_a: assert property (
		$fell(o_pins.oe_n) |-> !o_pins.oe_n [*8]) else $error("short read");
	done_free_a: assert property (
		o_done |-> o_pins.ce_n && !o_dq_oe) else $error("bus held");
	pd_quiet_a: assert property (
		!o_powerdown_reset_n |-> o_pins.ce_n && o_pins.we_n && !o_dq_oe) else $error("pd busy");
	wake_wait_a: assert property (
		$rose(o_powerdown_reset_n) |-> !o_req_ready [*8]) else $error("early ready");
	cover property (o_done);
	cover property ($fell(o_pins.oe_n));
	cover property ($rose(o_powerdown_reset_n));
endmodule // bbf_host_monitor
bind bbf_host bbf_host_monitor u_mon (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
	.o_req_ready(o_req_ready), .o_done(o_done), .o_pins(o_pins),
	.o_powerdown_reset_n(o_powerdown_reset_n), .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe));
`default_nettype wire

// >>> bench/tb.sv
// self-checking bench for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module tb;
	import bbf_pkg::*;
	localparam logic [7:0]	MFG = 8'hA5;
	localparam logic [7:0]	DEV = 8'h5A;
	logic	i_sys_clk = 0, i_rst_b = 0, i_req_valid = 0, i_powerdown = 0;
	logic	o_req_ready, o_done, o_timeout, pd_n, dq_oe;
	logic	exp_tmo = 0;
	logic	tq [$];
	logic [7:0]	o_rd_data, dq_o, fl_q, d;
	bbf_req_t	i_req = '0;
	bbf_pins_t	pins;
	logic [8:0]	q [$];
	logic [16:0]	a;
	int	fail_count = 0, comparisons = 0, seed = 10;
	wire logic [7:0]	dq = dq_oe ? dq_o : fl_q;
	always #5 i_sys_clk = ~i_sys_clk;
	bbf_host #(.ERASE_TIMEOUT(4000)) dut (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
		.i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready), .o_done(o_done),
		.o_timeout(o_timeout), .o_rd_data(o_rd_data), .i_powerdown(i_powerdown), .o_pins(pins),
		.o_powerdown_reset_n(pd_n), .o_dq_out(dq_o), .o_dq_oe(dq_oe), .i_dq_in(dq));
	// erase outlasts the poll limit, so the timeout path and a live suspend both get exercised
	bbf_flash_model #(.ERASE_CYC(6000), .MFG_ID(MFG), .DEV_ID(DEV)) u_flash (.i_clk(i_sys_clk),
		.i_pins(pins), .i_powerdown_reset_n(pd_n), .i_dq(dq), .o_dq(fl_q));
	task automatic err(input logic [7:0] e);
		fail_count++;
		$display("[ERR] %0t read %h expected %h", $time, o_rd_data, e);
	endtask
	task automatic summarize;
		if (fail_count == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [8:0] e);
		comparisons++;
		if (e[8] && o_rd_data !== e[7:0]) err(e[7:0]);
	endtask
	task automatic chk_tmo(input logic e);
		comparisons++;
		if (o_timeout !== e) begin
			fail_count++;
			$display("[ERR] %0t timeout flag %b expected %b", $time, o_timeout, e);
		end
	endtask
	always @(negedge i_sys_clk) if (o_done === 1'b1) begin
		if (q.size() == 0) err(8'h00);
		else begin
			chk(q.pop_front());
			chk_tmo(tq.pop_front());
		end
	end
	task automatic op(input bbf_op_t o, input logic [16:0] ad, input logic [7:0] dt,
		input logic [8:0] e);
		int n;
		n = 30000;
		while (o_req_ready !== 1'b1 && n > 0) begin
			@(negedge i_sys_clk);
			n--;
		end
		q.push_back(e);
		tq.push_back(exp_tmo);
		i_req = '{o, ad, dt};
		i_req_valid = 1;
		@(negedge i_sys_clk);
		i_req_valid = 0;
		while (o_done !== 1'b1 && n > 0) begin
			@(negedge i_sys_clk);
			n--;
		end
		if (n == 0) begin
			err(8'h00);
			summarize();
		end
	endtask
	initial begin
		repeat (5) @(negedge i_sys_clk);
		i_rst_b = 1;
		a = 17'($random(seed));
		d = 8'($random(seed)) & 8'h7F;
		op(OP_SIGNATURE, 17'h0_0000, 8'h00, {1'b1, MFG});
		op(OP_SIGNATURE, 17'h0_0001, 8'h00, {1'b1, DEV});
		op(OP_READ, a, 8'h00, 9'h1FF);
		op(OP_PROGRAM, a, d, 9'h180);
		op(OP_READ, a, 8'h00, {1'b1, d});
		op(OP_PROGRAM, a, 8'hFF, 9'h190);
		op(OP_STATUS, a, 8'h00, 9'h190);
		op(OP_CLEAR, a, 8'h00, 9'h000);
		op(OP_STATUS, a, 8'h00, 9'h180);
		exp_tmo = 1;
		op(OP_ERASE, a, 8'h00, 9'h100);
		exp_tmo = 0;
		op(OP_SUSPEND, a, 8'h00, 9'h000);
		op(OP_STATUS, a, 8'h00, 9'h100);
		op(OP_RESUME, a, 8'h00, 9'h000);
		repeat (2500) @(negedge i_sys_clk);
		op(OP_STATUS, a, 8'h00, 9'h180);
		op(OP_READ, a, 8'h00, 9'h1FF);
		i_powerdown = 1;
		repeat (20) @(negedge i_sys_clk);
		i_powerdown = 0;
		op(OP_READ, a ^ 17'h0_0001, 8'h00, 9'h1FF);
		// let the watcher take the last result before the verdict
		@(negedge i_sys_clk);
		if (q.size() != 0) err(8'h00);
		summarize();
	end
endmodule // tb
`default_nettype wire

// >>> hw/bbf_host.sv
// host controller that drives a boot-block flash over its asynchronous pins
`timescale 1ns/1ps
`default_nettype none
// How it works
// RQ1 - every command goes out as one or two write cycles; first byte is the command
// RQ2 - program and erase writes carry address and data for the device to latch
// RQ3 - read op writes FFH then reads array data
// RQ4 - program writes 40H then target address and data byte
// RQ5 - status op writes 70H then reads the status byte
// RQ6 - clear op writes 50H to clear latched fail flags
// RQ7 - erase writes 20H then D0H, both at the block address
// RQ8 - suspend writes B0H; resume writes D0H
// RQ9 - signature op writes 90H then reads address 0000H or 0001H
// RQ10 - device drives read data with power-down high, ce low, oe low, we high
// RQ11 - device floats data with ce low and oe, we high
// RQ12 - device floats data in standby when ce high
// RQ13 - device floats data in deep power-down when power-down low
// RQ14 - write cycle is ce low, oe high, we low, host drives data
// RQ15 - high-voltage signature read picks code by lowest address bit
// RQ16 - device byte program takes at least 15 us
// RQ17 - device block erase takes at least 1.3 s or 3 s; the bench model erases in ERASE_CYC cycles, 300 by default
// RQ18 - device relocks boot block within 100 ns of unlock removal
// RQ19 - read may follow a write with no recovery time
// RQ20 - host polls erase completion up to 20.9 s before timing out
// RQ21 - device enters read-array at power-up and leaving power-down
// RQ22 - after program or erase reads give status; bit 7 marks ready
// RQ23 - erase and program fail bits stay until status clear
// RQ24 - while programming only read-status is accepted by the device
// RQ25 - undefined command bytes leave mode and status unchanged
module bbf_host
	import bbf_pkg::*;
#(
	parameter longint ERASE_TIMEOUT = ERASE_TMO_CYC
) (
	// clock and reset
	input  wire logic              i_sys_clk,
	input  wire logic              i_rst_b,
	// user request port
	input  wire logic              i_req_valid,
	input  wire bbf_req_t          i_req,
	output logic                   o_req_ready,
	output logic                   o_done,
	output logic                   o_timeout,
	output logic [DATA_W-1:0]      o_rd_data,
	// user power-down request
	input  wire logic              i_powerdown,
	// flash pins
	output bbf_pins_t              o_pins,
	output logic                   o_powerdown_reset_n,
	output logic [DATA_W-1:0]      o_dq_out,
	output logic                   o_dq_oe,
	input  wire logic [DATA_W-1:0] i_dq_in
);
	typedef enum {
		ST_PWR, ST_IDLE, ST_WR_LOW, ST_WR_HIGH, ST_RD, ST_POLL_GAP, ST_DONE
	} bbf_state_t;

	bbf_state_t        state;
	bbf_req_t          cur;
	logic              second;
	logic [31:0]       cnt;
	longint            poll_cnt;
	logic [DATA_W-1:0] dq_s1;
	logic [DATA_W-1:0] dq_s2;

	// data pins cross from the device into our clock
	always_ff @(posedge i_sys_clk) begin
		dq_s1 <= i_dq_in;
		dq_s2 <= dq_s1;
	end

	// byte to put on the bus for the current write cycle
	function automatic logic [DATA_W-1:0] wr_byte(input bbf_req_t r, input logic sec);
		logic [DATA_W-1:0] b;
		b = CMD_READ_ARRAY;
		unique case (r.op)
			// RQ3 read array
			OP_READ:      b = CMD_READ_ARRAY;
			// RQ4 program pair
			OP_PROGRAM:   b = sec ? r.data : CMD_PROG_SETUP;
			// RQ7 erase pair
			OP_ERASE:     b = sec ? CMD_CONFIRM : CMD_ERASE_SETUP;
			// RQ5 status read
			OP_STATUS:    b = CMD_READ_STATUS;
			// RQ6 clear flags
			OP_CLEAR:     b = CMD_CLEAR_STATUS;
			// RQ8 suspend, resume
			OP_SUSPEND:   b = CMD_SUSPEND;
			OP_RESUME:    b = CMD_CONFIRM;
			// RQ9 signature entry
			OP_SIGNATURE: b = CMD_SIGNATURE;
		endcase
		return b;
	endfunction

	// ops that need a second write, and ops that end with a read
	function automatic logic two_writes(input bbf_op_t op);
		return (op == OP_PROGRAM) || (op == OP_ERASE);
	endfunction
	function automatic logic ends_in_read(input bbf_op_t op);
		return (op == OP_READ) || (op == OP_STATUS) || (op == OP_SIGNATURE)
			|| (op == OP_PROGRAM) || (op == OP_ERASE);
	endfunction
	function automatic logic polls(input bbf_op_t op);
		return (op == OP_PROGRAM) || (op == OP_ERASE);
	endfunction

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			state               <= ST_PWR;
			cur                 <= '0;
			second              <= 1'b0;
			cnt                 <= '0;
			poll_cnt            <= '0;
			o_req_ready         <= 1'b0;
			o_done              <= 1'b0;
			o_timeout           <= 1'b0;
			o_rd_data           <= '0;
			o_pins              <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0};
			o_powerdown_reset_n <= 1'b0;
			o_dq_out            <= '0;
			o_dq_oe             <= 1'b0;
		end else begin
			o_done <= 1'b0;
			unique case (state)
				// RQ21 wake recovery; device comes up in read-array
				ST_PWR: begin
					o_powerdown_reset_n <= !i_powerdown;
					if (i_powerdown) begin
						cnt <= '0;
					end else if (cnt >= 32'(PWR_RECOV_CYC)) begin
						state       <= ST_IDLE;
						o_req_ready <= 1'b1;
					end else begin
						cnt <= cnt + 32'd1;
					end
				end
				ST_IDLE: begin
					// RQ13 deep power-down floats the device
					if (i_powerdown) begin
						o_req_ready         <= 1'b0;
						o_powerdown_reset_n <= 1'b0;
						cnt                 <= '0;
						state               <= ST_PWR;
					end else if (i_req_valid) begin
						cur         <= i_req;
						second      <= 1'b0;
						o_req_ready <= 1'b0;
						o_timeout   <= 1'b0;
						poll_cnt    <= '0;
						cnt         <= '0;
						// RQ14 write strobe cycle
						o_pins      <= '{ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b0, addr: i_req.addr};
						o_dq_out    <= wr_byte(i_req, 1'b0);
						o_dq_oe     <= 1'b1;
						state       <= ST_WR_LOW;
					end
				end
				ST_WR_LOW: begin
					cnt <= cnt + 32'd1;
					if (cnt + 32'd1 >= 32'(WE_LOW_CYC)) begin
						// RQ2 rising we latches address and data
						o_pins.we_n <= 1'b1;
						cnt         <= '0;
						state       <= ST_WR_HIGH;
					end
				end
				ST_WR_HIGH: begin
					cnt <= cnt + 32'd1;
					if (cnt + 32'd1 >= 32'(WE_HIGH_CYC)) begin
						cnt <= '0;
						// RQ1 second bus cycle when the op needs it
						if (two_writes(cur.op) && !second) begin
							second      <= 1'b1;
							o_pins.we_n <= 1'b0;
							o_dq_out    <= wr_byte(cur, 1'b1);
							state       <= ST_WR_LOW;
						end else if (ends_in_read(cur.op)) begin
							// RQ19 read right after write
							o_dq_oe     <= 1'b0;
							o_pins.oe_n <= 1'b0;
							if (cur.op == OP_SIGNATURE) begin
								// RQ9 signature address
								o_pins.addr <= cur.addr[0] ? SIG_DEV_ADDR : SIG_MFG_ADDR;
							end
							state <= ST_RD;
						end else begin
							o_dq_oe <= 1'b0;
							o_pins  <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: cur.addr};
							state   <= ST_DONE;
						end
					end
				end
				// RQ10 device drives data on a read
				ST_RD: begin
					cnt      <= cnt + 32'd1;
					poll_cnt <= poll_cnt + 1;
					if (cnt + 32'd1 >= 32'(RD_CYC)) begin
						cnt         <= '0;
						o_rd_data   <= dq_s2;
						// status latches on oe fall; toggle oe before the next poll
						o_pins.oe_n <= 1'b1;
						// RQ22 poll until ready bit set
						if (polls(cur.op) && !dq_s2[SR_READY_BIT]) begin
							// RQ20 give up after the erase limit
							if (poll_cnt >= ERASE_TIMEOUT) begin
								o_timeout <= 1'b1;
								o_pins.ce_n <= 1'b1;
								state     <= ST_DONE;
							end else begin
								state <= ST_POLL_GAP;
							end
						end else begin
							// RQ12 standby between ops
							o_pins.ce_n <= 1'b1;
							state       <= ST_DONE;
						end
					end
				end
				// RQ11 output disabled while oe high
				ST_POLL_GAP: begin
					poll_cnt    <= poll_cnt + 1;
					o_pins.oe_n <= 1'b0;
					state       <= ST_RD;
				end
				ST_DONE: begin
					o_done      <= 1'b1;
					o_req_ready <= 1'b1;
					state       <= ST_IDLE;
				end
			endcase
		end
	end
endmodule : bbf_host
`default_nettype wire

// >>> hw/bbf_pkg.sv
// package: command codes, pin timing and status layout for the flash host controller
package bbf_pkg;
	localparam int ADDR_W = 17;
	localparam int DATA_W = 8;
	// command codes
	localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
	localparam logic [7:0] CMD_PROG_SETUP   = 8'h40;
	localparam logic [7:0] CMD_PROG_ALT     = 8'h10;
	localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
	localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
	localparam logic [7:0] CMD_CONFIRM      = 8'hD0;
	localparam logic [7:0] CMD_SUSPEND      = 8'hB0;
	localparam logic [7:0] CMD_SIGNATURE    = 8'h90;
	localparam logic [16:0] SIG_MFG_ADDR    = 17'h0_0000;
	localparam logic [16:0] SIG_DEV_ADDR    = 17'h0_0001;
	// status bit positions
	localparam int SR_READY_BIT  = 7;
	localparam int SR_ERASE_FAIL = 5;
	localparam int SR_PROG_FAIL  = 4;
	// timing, in ns and derived cycles at 100 MHz
	localparam int CLK_NS        = 10;
	localparam int WE_LOW_NS     = 40;
	localparam int WE_HIGH_NS    = 10;
	localparam int WR_CYCLE_NS   = 90;
	localparam int RD_ACCESS_NS  = 90;
	localparam int PWR_RECOV_NS  = 480;
	localparam int WE_LOW_CYC    = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
	localparam int WE_HIGH_CYC   = (WR_CYCLE_NS - WE_LOW_NS + CLK_NS - 1) / CLK_NS;
	// two sync stages sit between the pin and the sampled byte
	localparam int RD_CYC        = (RD_ACCESS_NS + CLK_NS - 1) / CLK_NS + 2;
	localparam int PWR_RECOV_CYC = (PWR_RECOV_NS + CLK_NS - 1) / CLK_NS;
	// erase poll timeout for the main block
	localparam int ERASE_TMO_MS  = 20900;
	localparam longint ERASE_TMO_CYC = longint'(ERASE_TMO_MS) * 1000 * 1000 / CLK_NS;
	// host operation codes
	typedef enum logic [2:0] {
		OP_READ, OP_PROGRAM, OP_ERASE, OP_STATUS, OP_CLEAR,
		OP_SUSPEND, OP_RESUME, OP_SIGNATURE
	} bbf_op_t;
	typedef struct packed {
		bbf_op_t            op;
		logic [ADDR_W-1:0]  addr;
		logic [DATA_W-1:0]  data;
	} bbf_req_t;
	typedef struct packed {
		logic               ce_n;
		logic               oe_n;
		logic               we_n;
		logic [ADDR_W-1:0]  addr;
	} bbf_pins_t;
endpackage : bbf_pkg
